// ### rtl/ppsw_status_word.sv
`timescale 1ns/1ps
// How it works
// - Bit 15 high while torque sits at its upper limit, else low.
// - Bit 13 sets when position deviation exceeds the following-error window.
// - Bit 13 clears only when alarm 10h or 30h is cleared.
// - Accepted new-set-point start sets bit 12 acknowledge.
// - Acknowledge drops when new-set-point returns low; zero without accepted start.
// - Bit 11 high while any limit sensor, prohibit, software or mechanical limit acts.
// - Halt low: bit 10 sets after completed move once in position window.
// - Halt low: interrupted move never sets target-reached.
// - Target-reached clears when a new move starts from completed state.
// - Halt high: bit 10 low while decelerating, high at zero command speed.
// - Bit 9 remote sets once initialization completes.
// - Bit 7 follows warning presence, clearing by itself.
// - Halt control bit stops the current operation.
// - No start accepted while halted, stopped, not enabled or unexcited.
module ppsw_status_word
   import ppsw_pkg::*;
#(
   parameter int SYNC_STAGES_UNUSED = 0
) (
   // Clock and reset
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   // Wishbone slave
   input  wire logic           wb_cyc_i,
   input  wire logic           wb_stb_i,
   input  wire logic           wb_we_i,
   input  wire logic [3:0]     wb_adr_i,
   input  wire logic [3:0]     wb_sel_i,
   input  wire logic [31:0]    wb_dat_i,
   output logic      [31:0]    wb_dat_o,
   output logic                wb_ack_o,
   // Motion core
   input  wire ppsw_core_type  core_i,
   input  wire ppsw_limit_type limit_pins_i,
   // Status
   output logic      [15:0]    status_word_o,
   output logic                halt_o,
   output logic                start_accept_o,
   output logic                irq_o
);
   ppsw_limit_type         limit_sync;
   logic [1:0]             ctrl_q;
   logic [IRQ_NUM-1:0]     mask_q;
   logic [IRQ_NUM-1:0]     irq_status;
   logic [IRQ_NUM-1:0]     events;
   logic                   irq_clear;
   logic                   new_sp_q;
   logic                   new_sp_rise;
   logic                   tlc_q;
   logic                   follow_q;
   logic                   ack_q;
   logic                   limit_q;
   logic                   treach_q;
   logic                   treach_d;
   logic                   remote_q;
   logic                   warn_q;
   logic                   halt_seen_q;
   ppsw_motion_type        mot_q;
   ppsw_motion_type        mot_d;
   logic                   bus_req;
   logic                   bus_wr;
   logic                   new_sp;
   logic                   halt;
   logic                   wr_ctrl;
   logic                   wr_mask;
   logic                   follow_release;
   logic                   limit_any;

   ppsw_sync #(
      .WIDTH ($bits(ppsw_limit_type))
   ) u_limit_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (limit_pins_i),
      .sync_o  (limit_sync)
   );

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes land at the edge on which the master sees ack
   assign bus_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   assign wr_ctrl = bus_wr && (wb_adr_i == REG_CONTROL);
   assign wr_mask = bus_wr && (wb_adr_i == REG_IRQ_MASK);
   assign limit_any = |limit_sync;
   assign new_sp  = ctrl_q[CTL_NEW_SP_BIT];
   assign halt    = ctrl_q[CTL_HALT_BIT];
   assign halt_o  = halt;

   // Bus answer one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            REG_STATUS_WORD: wb_dat_o <= {16'h0000, status_word_o};
            REG_CONTROL:     wb_dat_o <= {30'h0, ctrl_q};
            REG_IRQ_STATUS:  wb_dat_o <= {{(32-IRQ_NUM){1'b0}}, irq_status};
            REG_IRQ_MASK:    wb_dat_o <= {{(32-IRQ_NUM){1'b0}}, mask_q};
            default:         wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= wb_dat_i[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= '0;
      end else if (wr_mask) begin
         mask_q <= wb_dat_i[IRQ_NUM-1:0];
      end
   end

   assign irq_clear = bus_req && !wb_we_i && wb_adr_i == REG_IRQ_STATUS;

   // New-set-point edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         new_sp_q <= 1'b0;
      end else begin
         new_sp_q <= new_sp;
      end
   end

   assign new_sp_rise    = new_sp && !new_sp_q;
   // Start refused while halted or core not ready
   assign start_accept_o = new_sp_rise && !halt && core_i.start_ready;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (!new_sp) begin
         ack_q <= 1'b0;
      end else if (start_accept_o) begin
         ack_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tlc_q <= 1'b0;
      end else begin
         tlc_q <= core_i.torque_at_limit;
      end
   end

   // Only the deviation and overload alarm clears release the flag
   assign follow_release = core_i.alarm_clear &&
                           (core_i.alarm_code == ALM_DEVIATION || core_i.alarm_code == ALM_OVERLOAD);

   // Sticky until a qualifying alarm is cleared; a live deviation wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         follow_q <= 1'b0;
      end else if (core_i.deviation_over) begin
         follow_q <= 1'b1;
      end else if (follow_release) begin
         follow_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         limit_q <= 1'b0;
      end else begin
         limit_q <= limit_any;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         remote_q <= 1'b0;
      end else if (core_i.init_done) begin
         remote_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         warn_q <= 1'b0;
      end else begin
         warn_q <= core_i.warning_present;
      end
   end

   // Motion tracking for target reached with halt low
   always_comb begin
      mot_d = mot_q;
      case (mot_q)
         MOT_IDLE: begin
            if (start_accept_o) begin
               mot_d = MOT_MOVING;
            end
         end
         MOT_MOVING: begin
            if (core_i.move_abort || halt) begin
               mot_d = MOT_IDLE;
            end else if (core_i.move_done) begin
               mot_d = MOT_SETTLING;
            end
         end
         MOT_SETTLING: begin
            if (start_accept_o) begin
               mot_d = MOT_MOVING;
            end else if (core_i.move_abort || halt) begin
               mot_d = MOT_IDLE;
            end else if (core_i.in_position) begin
               mot_d = MOT_DONE;
            end
         end
         MOT_DONE: begin
            if (start_accept_o) begin
               mot_d = MOT_MOVING;
            end
         end
         default: mot_d = MOT_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mot_q <= MOT_IDLE;
      end else begin
         mot_q <= mot_d;
      end
   end

   // Halt reached once commanded speed falls to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_seen_q <= 1'b0;
      end else if (!halt) begin
         halt_seen_q <= 1'b0;
      end else if (core_i.cmd_speed_zero) begin
         halt_seen_q <= 1'b1;
      end
   end

   always_comb begin
      if (halt) begin
         treach_d = halt_seen_q || core_i.cmd_speed_zero;
      end else begin
         treach_d = (mot_d == MOT_DONE);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         treach_q <= 1'b0;
      end else begin
         treach_q <= treach_d;
      end
   end

   always_comb begin
      status_word_o                = STATUS_RESET;
      status_word_o[SW_TLC_BIT]    = tlc_q;
      status_word_o[SW_RSV14_BIT]  = 1'b0;
      status_word_o[SW_FOLLOW_BIT] = follow_q;
      status_word_o[SW_ACK_BIT]    = ack_q;
      status_word_o[SW_LIMIT_BIT]  = limit_q;
      status_word_o[SW_TREACH_BIT] = treach_q;
      status_word_o[SW_REMOTE_BIT] = remote_q;
      status_word_o[SW_RSV8_BIT]   = 1'b0;
      status_word_o[SW_WARN_BIT]   = warn_q;
   end

   // Rising edges of the ack, target-reached, following, torque and limit flags raise interrupt events
   always_comb begin
      events                 = '0;
      events[IRQ_ACK_BIT]    = start_accept_o;
      events[IRQ_TREACH_BIT] = treach_d && !treach_q;
      events[IRQ_FOLLOW_BIT] = core_i.deviation_over && !follow_q;
      events[IRQ_TLC_BIT]    = core_i.torque_at_limit && !tlc_q;
      events[IRQ_LIMIT_BIT]  = limit_any && !limit_q;
   end

   ppsw_irq #(
      .N (IRQ_NUM)
   ) u_irq (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .event_i  (events),
      .clear_i  (irq_clear),
      .mask_i   (mask_q),
      .status_o (irq_status),
      .irq_o    (irq_o)
   );
endmodule

// ### rtl/ppsw_pkg.sv
package ppsw_pkg;
   // Status word bit positions
   localparam int SW_TLC_BIT      = 15;
   localparam int SW_RSV14_BIT    = 14;
   localparam int SW_FOLLOW_BIT   = 13;
   localparam int SW_ACK_BIT      = 12;
   localparam int SW_LIMIT_BIT    = 11;
   localparam int SW_TREACH_BIT   = 10;
   localparam int SW_REMOTE_BIT   = 9;
   localparam int SW_RSV8_BIT     = 8;
   localparam int SW_WARN_BIT     = 7;

   // Alarm codes that release the following-error flag
   localparam logic [7:0] ALM_DEVIATION = 8'h10;
   localparam logic [7:0] ALM_OVERLOAD  = 8'h30;

   // Register byte offsets
   localparam logic [3:0] REG_STATUS_WORD = 4'h0;
   localparam logic [3:0] REG_CONTROL     = 4'h4;
   localparam logic [3:0] REG_IRQ_STATUS  = 4'h8;
   localparam logic [3:0] REG_IRQ_MASK    = 4'hc;

   // Control register fields
   localparam int CTL_NEW_SP_BIT = 0;
   localparam int CTL_HALT_BIT   = 1;

   // Interrupt event bit positions
   localparam int IRQ_NUM        = 5;
   localparam int IRQ_ACK_BIT    = 0;
   localparam int IRQ_TREACH_BIT = 1;
   localparam int IRQ_FOLLOW_BIT = 2;
   localparam int IRQ_TLC_BIT    = 3;
   localparam int IRQ_LIMIT_BIT  = 4;

   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [1:0]  CTRL_RESET   = 2'h0;

   // Motion state for target-reached tracking
   typedef enum logic [1:0] {
      MOT_IDLE     = 2'b00,
      MOT_MOVING   = 2'b01,
      MOT_SETTLING = 2'b10,
      MOT_DONE     = 2'b11
   } ppsw_motion_type;

   // Inputs from the drive's motion core
   typedef struct packed {
      logic       torque_at_limit;
      logic       deviation_over;
      logic       alarm_clear;
      logic [7:0] alarm_code;
      logic       start_ready;
      logic       move_done;
      logic       move_abort;
      logic       in_position;
      logic       cmd_speed_zero;
      logic       init_done;
      logic       warning_present;
   } ppsw_core_type;

   // Limit sources
   typedef struct packed {
      logic forward_limit_sensor;
      logic reverse_limit_sensor;
      logic forward_prohibit_input;
      logic reverse_prohibit_input;
      logic software_limit;
      logic mechanical_limit;
   } ppsw_limit_type;
endpackage

// ### rtl/ppsw_sync.sv
`timescale 1ns/1ps
module ppsw_sync #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// ### rtl/ppsw_irq.sv
`timescale 1ns/1ps
module ppsw_irq #(
   parameter int N = 5
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Events and control
   input  wire logic [N-1:0] event_i,
   input  wire logic         clear_i,
   input  wire logic [N-1:0] mask_i,
   // Outputs
   output logic      [N-1:0] status_o,
   output logic              irq_o
);
   // Set wins over a read-clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= '0;
      end else if (clear_i) begin
         status_o <= event_i;
      end else begin
         status_o <= status_o | event_i;
      end
   end

   assign irq_o = |(status_o & mask_i);
endmodule

// ### testbench/ppsw_core_model.sv
`timescale 1ns/1ps
module ppsw_core_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Commands
   input  wire logic start_i,
   input  wire logic halt_i,
   input  wire logic abort_i,
   // Motion status
   output logic      done_o,
   output logic      in_pos_o,
   output logic      zero_o
);
   logic [3:0] cnt_q;
   logic [3:0] dec_q;
   // Stop or abort kills the move
   always_ff @(posedge clk_i) begin
      if (rst_i || abort_i || halt_i) begin
         cnt_q <= 4'h0;
      end else if (start_i) begin
         cnt_q <= 4'hc;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      done_o <= !rst_i && !abort_i && !halt_i && cnt_q == 4'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         in_pos_o <= 1'b0;
      end else if (done_o) begin
         in_pos_o <= 1'b1;
      end
   end
   // Deceleration time under halt
   always_ff @(posedge clk_i) begin
      if (rst_i || !halt_i) begin
         dec_q <= 4'h8;
      end else if (dec_q != 4'h0) begin
         dec_q <= dec_q - 4'h1;
      end
   end
   assign zero_o = halt_i && dec_q == 4'h0;
endmodule

// ### testbench/ppsw_status_word_sva.sv
`timescale 1ns/1ps
module ppsw_status_word_sva
   import ppsw_pkg::*;
(
   // Clock and reset
   input wire logic           clk_i,
   input wire logic           rst_i,
   // Watched ports
   input wire logic           wb_cyc_i,
   input wire logic           wb_stb_i,
   input wire logic           wb_ack_o,
   input wire ppsw_core_type  core_i,
   input wire ppsw_limit_type limit_pins_i,
   input wire logic [15:0]    status_word_o,
   input wire logic           halt_o,
   input wire logic           start_accept_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence taken_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence clear_s;
      $past(core_i.alarm_clear) || $past(core_i.alarm_clear, 2);
   endsequence
   ack_time_a: assert property (taken_s |=> wb_ack_o)
      else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   tlc_flag_a: assert property (1 |=> status_word_o[SW_TLC_BIT] == $past(core_i.torque_at_limit))
      else $error("torque flag wrong");
   limit_flag_a: assert property (1 |=> ##2 status_word_o[SW_LIMIT_BIT] == $past(|limit_pins_i, 3))
      else $error("limit flag wrong");
   rsvd_zero_a: assert property ((status_word_o & 16'h417f) == 16'h0)
      else $error("reserved bits set");
   start_gate_a: assert property (start_accept_o |-> !halt_o && core_i.start_ready)
      else $error("start accepted wrongly");
   sp_ack_a: assert property (start_accept_o |=> status_word_o[SW_ACK_BIT])
      else $error("set point ack missing");
   follow_set_a: assert property (core_i.deviation_over |-> ##[1:2] status_word_o[SW_FOLLOW_BIT])
      else $error("following flag missing");
   follow_clr_a: assert property ($fell(status_word_o[SW_FOLLOW_BIT]) |-> clear_s)
      else $error("following flag dropped");
   warn_flag_a: assert property (1 |=> status_word_o[SW_WARN_BIT] == $past(core_i.warning_present))
      else $error("warning flag wrong");
   remote_set_a: assert property (core_i.init_done |=> status_word_o[SW_REMOTE_BIT])
      else $error("remote flag missing");
   halt_reach_a: assert property (halt_o && core_i.cmd_speed_zero |=> status_word_o[SW_TREACH_BIT])
      else $error("halt target flag missing");
   reach_clear_a: assert property (start_accept_o |=> !status_word_o[SW_TREACH_BIT])
      else $error("target flag kept on start");
endmodule
bind ppsw_status_word ppsw_status_word_sva ppsw_status_word_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .core_i, .limit_pins_i, .status_word_o, .halt_o, .start_accept_o);

// ### testbench/tb_ppsw_status_word.sv
`timescale 1ns/1ps
module tb_ppsw_status_word
   import ppsw_pkg::*;
;
   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic           cyc = 1'b0;
   logic           stb = 1'b0;
   logic           we = 1'b0;
   logic [3:0]     adr = 4'h0;
   logic [3:0]     sel = 4'hf;
   logic [31:0]    dat = 32'h0;
   logic [31:0]    rdat;
   logic [31:0]    q;
   logic           ack, halt, acc, irq, done, inpos, zero;
   logic [15:0]    sw;
   ppsw_core_type  c = '0;
   ppsw_core_type  cw;
   ppsw_limit_type lim = '0;
   logic [7:0]     codes [2] = '{ALM_DEVIATION, ALM_OVERLOAD};
   int             fails = 0;
   int             samples_checked = 0;
   always #2.5 clk = ~clk;
   always_comb begin
      cw = c;
      cw.move_done = done;
      cw.in_position = inpos;
      cw.cmd_speed_zero = zero;
   end
   ppsw_status_word ppsw_status_word_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .core_i(cw), .limit_pins_i(lim), .status_word_o(sw), .halt_o(halt), .start_accept_o(acc), .irq_o(irq));
   ppsw_core_model ppsw_core_model_inst (.clk_i(clk), .rst_i(rst), .start_i(acc), .halt_i(halt),
      .abort_i(c.move_abort), .done_o(done), .in_pos_o(inpos), .zero_o(zero));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      we <= w;
      dat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic st(input logic [15:0] m, input logic [15:0] e);
      wb(REG_STATUS_WORD, 1'b0, 32'h0);
      chk(q & {16'hffff, m}, {16'h0, e});
   endtask
   task automatic alm(input logic [7:0] code);
      c.alarm_code <= code;
      c.alarm_clear <= 1'b1;
      wt(1);
      c.alarm_clear <= 1'b0;
      wt(3);
   endtask
   task automatic conclude;
      $display("checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      wt(10);
      rst <= 1'b0;
      wt(1);
      st(16'hffff, 16'h0);
      c.torque_at_limit <= 1'b1;
      c.init_done <= 1'b1;
      c.warning_present <= 1'b1;
      lim <= 6'h01;
      wt(5);
      st(16'hffff, 16'h8a80);
      for (int i = 1; i < 6; i++) begin
         lim <= 6'h01 << i;
         wt(5);
         st(16'h0800, 16'h0800);
      end
      lim <= '0;
      c.torque_at_limit <= 1'b0;
      c.warning_present <= 1'b0;
      wt(5);
      st(16'hffff, 16'h0200);
      wb(4'h2, 1'b0, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wb(REG_IRQ_MASK, 1'b1, 32'h08);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      wb(REG_IRQ_STATUS, 1'b0, 32'h0);
      chk(q & 32'h18, 32'h18);
      wt(2);
      chk({31'h0, irq}, 32'h0);
      sel <= 4'he;
      wb(REG_IRQ_MASK, 1'b1, 32'h1f);
      sel <= 4'hf;
      wb(REG_IRQ_MASK, 1'b0, 32'h0);
      chk(q, 32'h08);
      $display("flags and irq test done");
      foreach (codes[i]) begin
         c.deviation_over <= 1'b1;
         wt(3);
         c.deviation_over <= 1'b0;
         alm(8'h20);
         st(16'h2000, 16'h2000);
         alm(codes[i]);
         st(16'h2000, 16'h0);
      end
      $display("following test done");
      c.start_ready <= 1'b1;
      wb(REG_CONTROL, 1'b1, 32'h1);
      st(16'h1400, 16'h1000);
      wt(20);
      st(16'h1400, 16'h1400);
      wb(REG_CONTROL, 1'b1, 32'h0);
      st(16'h1400, 16'h0400);
      wb(REG_CONTROL, 1'b1, 32'h1);
      st(16'h0400, 16'h0);
      c.move_abort <= 1'b1;
      wt(1);
      c.move_abort <= 1'b0;
      wt(20);
      st(16'h0400, 16'h0);
      wb(REG_CONTROL, 1'b1, 32'h0);
      $display("set point test done");
      wb(REG_CONTROL, 1'b1, 32'h1);
      wb(REG_CONTROL, 1'b1, 32'h2);
      st(16'h0400, 16'h0);
      wt(12);
      st(16'h0400, 16'h0400);
      chk({31'h0, halt}, 32'h1);
      wb(REG_CONTROL, 1'b0, 32'h0);
      chk(q, 32'h2);
      wb(REG_CONTROL, 1'b1, 32'h3);
      st(16'h1000, 16'h0);
      wb(REG_CONTROL, 1'b1, 32'h0);
      c.start_ready <= 1'b0;
      wt(4);
      wb(REG_CONTROL, 1'b1, 32'h1);
      st(16'h1000, 16'h0);
      $display("halt test done");
      conclude();
   end
endmodule
